//--- hdl/acl_entry_l2_arp_matcher.sv
// Function
// - Source address checked only for Ethernet/ARP type
// - Group class needs multicast destination
// - All-ones class needs broadcast destination
// - Individual class needs unicast destination
// - VLAN Specific needs identifier equality
// - Priority compared unless Any
// - ARP criteria only for ARP frame type
// - Opcode kind Any, ARP or RARP
// - Opcode kind Other: unknown opcodes only
// - Request/reply selects request or reply opcodes
// - Sender address Any, Host or Network
// - Target address Any, Host or Network
// - Sender hardware equals source flag
// - Target hardware equals source flag
// - Length flag checks lengths 6 and 4
// - Hardware type flag checks Ethernet
// - Ethernet type needs type 0x0600 or above, not ARP/IP
// - Hit counter counts every hit
`timescale 1ns/10ps
`default_nettype none
module acl_entry_l2_arp_matcher (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frm_valid,
  input wire logic [15:0] frm_len_type,
  input wire logic [47:0] frm_source_hw_addr,
  input wire logic [47:0] frm_dest_hw_addr,
  input wire logic [11:0] frm_vid,
  input wire logic [2:0] frm_prio,
  input wire logic [15:0] arp_op,
  input wire logic [15:0] arp_hw_type,
  input wire logic [15:0] arp_proto_type,
  input wire logic [7:0] arp_hw_len,
  input wire logic [7:0] arp_proto_len,
  input wire logic [47:0] arp_sha,
  input wire logic [31:0] arp_spa,
  input wire logic [47:0] arp_tha,
  input wire logic [31:0] arp_tpa,
  output logic entry_hit
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic flag_ok(input logic [1:0] sel, input logic c);
    flag_ok = (sel == acl_pkg::FLAG_SET) ? c :
              (sel == acl_pkg::FLAG_CLR) ? !c : 1'b1;
  endfunction

  function automatic logic ip_ok(input logic [1:0] m,
                                 input logic [31:0] a,
                                 input logic [31:0] v,
                                 input logic [31:0] k);
    ip_ok = (m == acl_pkg::IPM_HOST) ? (a == v) :
            (m == acl_pkg::IPM_NET) ? ((a & k) == (v & k)) : 1'b1;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [23:0] cfg_r;
  logic [17:0] arp_cfg_r;
  logic [31:0] src_lo_r;
  logic [15:0] src_hi_r;
  logic [31:0] dst_lo_r;
  logic [15:0] dst_hi_r;
  logic [31:0] spa_r;
  logic [31:0] spa_mask_r;
  logic [31:0] tpa_r;
  logic [31:0] tpa_mask_r;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic hit_r;
  logic hit_nxt;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // ****************************************
  // APB decode
  // ****************************************
  // Two-cycle access phase keeps read data registered
  wire acc_first = psel & penable & !pready_r;
  wire commit = psel & penable & pready_r;
  wire wr = commit & pwrite;
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= acl_pkg::OFS_HIT_CNT);
  wire cnt_clr = wr && (paddr == acl_pkg::OFS_HIT_CNT);
  logic [31:0] rd_mux;
  assign rd_mux =
    (paddr == acl_pkg::OFS_CFG) ? {8'h00, cfg_r} :
    (paddr == acl_pkg::OFS_ARP) ? {14'h0000, arp_cfg_r} :
    (paddr == acl_pkg::OFS_SRC_LO) ? src_lo_r :
    (paddr == acl_pkg::OFS_SRC_HI) ? {16'h0000, src_hi_r} :
    (paddr == acl_pkg::OFS_DST_LO) ? dst_lo_r :
    (paddr == acl_pkg::OFS_DST_HI) ? {16'h0000, dst_hi_r} :
    (paddr == acl_pkg::OFS_SPA) ? spa_r :
    (paddr == acl_pkg::OFS_SPA_MASK) ? spa_mask_r :
    (paddr == acl_pkg::OFS_TPA) ? tpa_r :
    (paddr == acl_pkg::OFS_TPA_MASK) ? tpa_mask_r :
    (paddr == acl_pkg::OFS_HIT_CNT) ? cnt_r : 32'h0000_0000;

  // ****************************************
  // Configuration fields
  // ****************************************
  wire [2:0] ft = cfg_r[acl_pkg::FT_LSB +: 3];
  wire src_spec = cfg_r[acl_pkg::SRC_SPEC_BIT];
  wire [2:0] dst_cls = cfg_r[acl_pkg::DST_LSB +: 3];
  wire vid_spec = cfg_r[acl_pkg::VID_SPEC_BIT];
  wire prio_spec = cfg_r[acl_pkg::PRIO_SPEC_BIT];
  wire [2:0] prio_val = cfg_r[acl_pkg::PRIO_LSB +: 3];
  wire [11:0] vid_val = cfg_r[acl_pkg::VID_LSB +: 12];
  wire [1:0] opk = arp_cfg_r[acl_pkg::OPK_LSB +: 2];
  wire [1:0] rr = arp_cfg_r[acl_pkg::RR_LSB +: 2];
  wire [1:0] spm = arp_cfg_r[acl_pkg::SPM_LSB +: 2];
  wire [1:0] tpm = arp_cfg_r[acl_pkg::TPM_LSB +: 2];
  wire [1:0] sha_f = arp_cfg_r[acl_pkg::SHA_LSB +: 2];
  wire [1:0] tha_f = arp_cfg_r[acl_pkg::THA_LSB +: 2];
  wire [1:0] len_f = arp_cfg_r[acl_pkg::LEN_LSB +: 2];
  wire [1:0] hrd_f = arp_cfg_r[acl_pkg::HRD_LSB +: 2];
  wire [1:0] pro_f = arp_cfg_r[acl_pkg::PRO_LSB +: 2];
  wire [47:0] src_val = {src_hi_r, src_lo_r};
  wire [47:0] dst_val = {dst_hi_r, dst_lo_r};

  // ****************************************
  // Frame type
  // ****************************************
  wire is_arp = frm_len_type == acl_pkg::ET_ARP;
  wire is_ip4 = frm_len_type == acl_pkg::ET_IP4;
  wire is_ip6 = frm_len_type == acl_pkg::ET_IP6;
  wire is_eth = (frm_len_type >= acl_pkg::ETH_TYPE_MIN) &&
                !is_arp && !is_ip4 && !is_ip6;
  wire ft_ok = (ft == acl_pkg::FT_ANY) ||
               (ft == acl_pkg::FT_ETH && is_eth) ||
               (ft == acl_pkg::FT_ARP && is_arp) ||
               (ft == acl_pkg::FT_IP4 && is_ip4) ||
               (ft == acl_pkg::FT_IP6 && is_ip6);

  // ****************************************
  // Layer-2 criteria
  // ****************************************
  wire src_apply = (ft == acl_pkg::FT_ETH) || (ft == acl_pkg::FT_ARP);
  wire src_ok = !src_apply || !src_spec ||
                (frm_source_hw_addr == src_val);
  wire dst_group = frm_dest_hw_addr[40];
  wire dst_bcast = &frm_dest_hw_addr;
  wire dst_ok =
    (dst_cls == acl_pkg::DST_GROUP) ? dst_group :
    (dst_cls == acl_pkg::DST_ALL_ONES) ? dst_bcast :
    (dst_cls == acl_pkg::DST_INDIV) ? !dst_group :
    (dst_cls == acl_pkg::DST_SPEC) ? (frm_dest_hw_addr == dst_val) :
    1'b1;
  wire vid_ok = !vid_spec || (frm_vid == vid_val);
  wire prio_ok = !prio_spec || (frm_prio == prio_val);

  // ****************************************
  // ARP criteria
  // ****************************************
  wire op_arp = (arp_op == acl_pkg::OP_ARP_REQ) ||
                (arp_op == acl_pkg::OP_ARP_REP);
  wire op_rarp = (arp_op == acl_pkg::OP_RARP_REQ) ||
                 (arp_op == acl_pkg::OP_RARP_REP);
  wire op_req = (arp_op == acl_pkg::OP_ARP_REQ) ||
                (arp_op == acl_pkg::OP_RARP_REQ);
  wire op_rep = (arp_op == acl_pkg::OP_ARP_REP) ||
                (arp_op == acl_pkg::OP_RARP_REP);
  wire opk_ok = (opk == acl_pkg::OPK_ARP) ? op_arp :
                (opk == acl_pkg::OPK_RARP) ? op_rarp :
                (opk == acl_pkg::OPK_OTHER) ? !(op_arp || op_rarp) :
                1'b1;
  wire rr_ok = (rr == acl_pkg::RR_REQ) ? op_req :
               (rr == acl_pkg::RR_REPLY) ? op_rep : 1'b1;
  wire spa_ok = ip_ok(spm, arp_spa, spa_r, spa_mask_r);
  wire tpa_ok = ip_ok(tpm, arp_tpa, tpa_r, tpa_mask_r);
  wire sha_ok = flag_ok(sha_f, arp_sha == frm_source_hw_addr);
  wire tha_ok = flag_ok(tha_f, arp_tha == frm_source_hw_addr);
  wire len_eq = (arp_hw_len == acl_pkg::HW_LEN_ETH) &&
                (arp_proto_len == acl_pkg::PROTO_LEN_IP);
  wire len_ok = flag_ok(len_f, len_eq);
  wire hrd_eq = arp_hw_type == acl_pkg::HW_TYPE_ETH;
  wire hrd_ok = flag_ok(hrd_f, hrd_eq);
  wire pro_eq = arp_proto_type == acl_pkg::PROTO_TYPE_IP;
  wire pro_ok = flag_ok(pro_f, pro_eq);
  wire arp_all = opk_ok && rr_ok && spa_ok && tpa_ok && sha_ok &&
                 tha_ok && len_ok && hrd_ok && pro_ok;
  wire arp_ok = (ft != acl_pkg::FT_ARP) || arp_all;

  // ****************************************
  // Hit and counter
  // ****************************************
  wire all_ok = ft_ok && src_ok && dst_ok && vid_ok && prio_ok &&
                arp_ok;
  assign hit_nxt = frm_valid && all_ok;
  // A hit in the clearing cycle is kept as a count of one
  assign cnt_nxt = hit_nxt ? (cnt_clr ? 32'h0000_0001 : cnt_r + 32'h1) :
                   (cnt_clr ? 32'h0000_0000 : cnt_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_r <= 1'b0;
      cnt_r <= acl_pkg::RST_ZERO;
    end else begin
      hit_r <= hit_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      prdata_r <= acl_pkg::RST_ZERO;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc_first;
      if (acc_first) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= !mapped;
      end else begin
        prdata_r <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= acl_pkg::RST_ZERO[23:0];
      arp_cfg_r <= acl_pkg::RST_ZERO[17:0];
      src_lo_r <= acl_pkg::RST_ZERO;
      src_hi_r <= acl_pkg::RST_ZERO[15:0];
      dst_lo_r <= acl_pkg::RST_ZERO;
      dst_hi_r <= acl_pkg::RST_ZERO[15:0];
      spa_r <= acl_pkg::RST_ZERO;
      spa_mask_r <= acl_pkg::RST_ZERO;
      tpa_r <= acl_pkg::RST_ZERO;
      tpa_mask_r <= acl_pkg::RST_ZERO;
    end else if (wr) begin
      case (paddr)
        acl_pkg::OFS_CFG: cfg_r <= pwdata[23:0];
        acl_pkg::OFS_ARP: arp_cfg_r <= pwdata[17:0];
        acl_pkg::OFS_SRC_LO: src_lo_r <= pwdata;
        acl_pkg::OFS_SRC_HI: src_hi_r <= pwdata[15:0];
        acl_pkg::OFS_DST_LO: dst_lo_r <= pwdata;
        acl_pkg::OFS_DST_HI: dst_hi_r <= pwdata[15:0];
        acl_pkg::OFS_SPA: spa_r <= pwdata;
        acl_pkg::OFS_SPA_MASK: spa_mask_r <= pwdata;
        acl_pkg::OFS_TPA: tpa_r <= pwdata;
        acl_pkg::OFS_TPA_MASK: tpa_mask_r <= pwdata;
        default: ;
      endcase
    end
  end

  assign entry_hit = hit_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_hit_all_match: assert property (
    frm_valid && ft_ok && src_ok && dst_ok && vid_ok && prio_ok && arp_ok
    |=> entry_hit)
    else $error("hit missing for matching frame");
  a_no_valid_hit: assert property (
    !frm_valid |=> !entry_hit)
    else $error("hit without frame");
  a_bcast_class: assert property (
    frm_valid && dst_cls == acl_pkg::DST_ALL_ONES && !(&frm_dest_hw_addr)
    |=> !entry_hit)
    else $error("non-broadcast hit in broadcast class");
  a_group_class: assert property (
    frm_valid && dst_cls == acl_pkg::DST_GROUP && !frm_dest_hw_addr[40]
    |=> !entry_hit)
    else $error("unicast hit in multicast class");
  a_indiv_class: assert property (
    frm_valid && dst_cls == acl_pkg::DST_INDIV && frm_dest_hw_addr[40]
    |=> !entry_hit)
    else $error("multicast hit in unicast class");
  a_vlan_spec: assert property (
    frm_valid && vid_spec && frm_vid != vid_val |=> !entry_hit)
    else $error("hit with wrong vlan");
  a_prio_spec: assert property (
    frm_valid && prio_spec && frm_prio != prio_val |=> !entry_hit)
    else $error("hit with wrong priority");
  a_eth_type: assert property (
    frm_valid && ft == acl_pkg::FT_ETH &&
    (frm_len_type < acl_pkg::ETH_TYPE_MIN || is_arp) |=> !entry_hit)
    else $error("non ethernet-type frame hit");
  a_opk_other: assert property (
    frm_valid && ft == acl_pkg::FT_ARP && opk == acl_pkg::OPK_OTHER &&
    arp_op == acl_pkg::OP_ARP_REQ |=> !entry_hit)
    else $error("known opcode hit under other");
  a_cnt_step: assert property (
    hit_nxt && !cnt_clr |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("counter did not step on hit");
  a_cnt_hold: assert property (
    !hit_nxt && !cnt_clr |=> $stable(cnt_r))
    else $error("counter moved without hit");
endmodule
`default_nettype wire

//--- hdl/acl_pkg.sv
package acl_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_ARP = 8'h04;
  localparam logic [7:0] OFS_SRC_LO = 8'h08;
  localparam logic [7:0] OFS_SRC_HI = 8'h0c;
  localparam logic [7:0] OFS_DST_LO = 8'h10;
  localparam logic [7:0] OFS_DST_HI = 8'h14;
  localparam logic [7:0] OFS_SPA = 8'h18;
  localparam logic [7:0] OFS_SPA_MASK = 8'h1c;
  localparam logic [7:0] OFS_TPA = 8'h20;
  localparam logic [7:0] OFS_TPA_MASK = 8'h24;
  localparam logic [7:0] OFS_HIT_CNT = 8'h28;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int FT_LSB = 0;
  localparam int SRC_SPEC_BIT = 3;
  localparam int DST_LSB = 4;
  localparam int VID_SPEC_BIT = 7;
  localparam int PRIO_SPEC_BIT = 8;
  localparam int PRIO_LSB = 9;
  localparam int VID_LSB = 12;
  localparam int OPK_LSB = 0;
  localparam int RR_LSB = 2;
  localparam int SPM_LSB = 4;
  localparam int TPM_LSB = 6;
  localparam int SHA_LSB = 8;
  localparam int THA_LSB = 10;
  localparam int LEN_LSB = 12;
  localparam int HRD_LSB = 14;
  localparam int PRO_LSB = 16;
  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [2:0] FT_ANY = 3'h0;
  localparam logic [2:0] FT_ETH = 3'h1;
  localparam logic [2:0] FT_ARP = 3'h2;
  localparam logic [2:0] FT_IP4 = 3'h3;
  localparam logic [2:0] FT_IP6 = 3'h4;
  localparam logic [2:0] DST_ANY = 3'h0;
  localparam logic [2:0] DST_GROUP = 3'h1;
  localparam logic [2:0] DST_ALL_ONES = 3'h2;
  localparam logic [2:0] DST_INDIV = 3'h3;
  localparam logic [2:0] DST_SPEC = 3'h4;
  localparam logic [1:0] SEL_ANY = 2'h0;
  localparam logic [1:0] FLAG_CLR = 2'h1;
  localparam logic [1:0] FLAG_SET = 2'h2;
  localparam logic [1:0] IPM_HOST = 2'h1;
  localparam logic [1:0] IPM_NET = 2'h2;
  localparam logic [1:0] OPK_ARP = 2'h1;
  localparam logic [1:0] OPK_RARP = 2'h2;
  localparam logic [1:0] OPK_OTHER = 2'h3;
  localparam logic [1:0] RR_REQ = 2'h1;
  localparam logic [1:0] RR_REPLY = 2'h2;
  localparam logic [15:0] ETH_TYPE_MIN = 16'h0600;
  localparam logic [15:0] ET_ARP = 16'h0806;
  localparam logic [15:0] ET_IP4 = 16'h0800;
  localparam logic [15:0] ET_IP6 = 16'h86dd;
  localparam logic [15:0] OP_ARP_REQ = 16'h0001;
  localparam logic [15:0] OP_ARP_REP = 16'h0002;
  localparam logic [15:0] OP_RARP_REQ = 16'h0003;
  localparam logic [15:0] OP_RARP_REP = 16'h0004;
  localparam logic [7:0] HW_LEN_ETH = 8'h06;
  localparam logic [7:0] PROTO_LEN_IP = 8'h04;
  localparam logic [15:0] HW_TYPE_ETH = 16'h0001;
  localparam logic [15:0] PROTO_TYPE_IP = 16'h0800;
endpackage

//--- tb/acl_frame_src.sv
`timescale 1ns/10ps
`default_nettype none
module acl_frame_src (
  input wire logic clk,
  output logic frm_valid,
  output logic [15:0] frm_len_type,
  output logic [47:0] frm_source_hw_addr,
  output logic [47:0] frm_dest_hw_addr,
  output logic [11:0] frm_vid,
  output logic [2:0] frm_prio,
  output logic [15:0] arp_op,
  output logic [15:0] arp_hw_type,
  output logic [15:0] arp_proto_type,
  output logic [7:0] arp_hw_len,
  output logic [7:0] arp_proto_len,
  output logic [47:0] arp_sha,
  output logic [31:0] arp_spa,
  output logic [47:0] arp_tha,
  output logic [31:0] arp_tpa
);
  logic [350:0] fr;
  assign {frm_len_type, frm_source_hw_addr, frm_dest_hw_addr, frm_vid,
    frm_prio, arp_op, arp_hw_type, arp_proto_type, arp_hw_len,
    arp_proto_len, arp_sha, arp_spa, arp_tha, arp_tpa} = fr;
  initial begin
    frm_valid = 1'b0;
    fr = '0;
  end
  function automatic logic [47:0] r48();
    r48 = {16'($urandom()), $urandom()};
  endfunction
  function automatic logic [31:0] near(input logic [31:0] h);
    case ($urandom() % 3)
      0: near = h;
      1: near = h ^ 32'h0000_0001;
      default: near = $urandom();
    endcase
  endfunction
  // *****************************
  // One frame, then idle
  // *****************************
  // Each field follows its hint one time in two or three, else the entry would almost never hit
  task automatic send(input logic [47:0] s_h, input logic [47:0] d_h,
    input logic [31:0] sp_h, input logic [31:0] tp_h,
    input logic [11:0] v_h, input logic [2:0] p_h);
    logic [15:0] lt;
    logic [47:0] s;
    logic [47:0] d;
    case ($urandom() % 6)
      0, 1: lt = acl_pkg::ET_ARP;
      2: lt = acl_pkg::ET_IP4;
      3: lt = acl_pkg::ET_IP6;
      4: lt = 16'h05ff;
      default: lt = 16'h0600 + 16'($urandom() % 3);
    endcase
    s = ($urandom() % 2) ? s_h : r48();
    case ($urandom() % 3)
      0: d = d_h;
      1: d = 48'hffff_ffff_ffff;
      default: d = r48();
    endcase
    @(posedge clk);
    frm_valid <= 1'b1;
    fr <= {lt, s, d, ($urandom() % 2) ? v_h : 12'($urandom()),
      ($urandom() % 2) ? p_h : 3'($urandom()), 16'($urandom() % 6),
      ($urandom() % 2) ? 16'h0001 : 16'h0006,
      ($urandom() % 2) ? 16'h0800 : 16'h0806,
      ($urandom() % 2) ? 8'h06 : 8'h08, ($urandom() % 2) ? 8'h04 : 8'h10,
      ($urandom() % 2) ? s : r48(), near(sp_h),
      ($urandom() % 2) ? s : r48(), near(tp_h)};
    @(posedge clk);
    frm_valid <= 1'b0;
    // Stale fields are inverted so they never look like a held frame
    fr <= ~fr;
  endtask
endmodule
`default_nettype wire

//--- tb/acl_entry_l2_arp_matcher_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module acl_entry_l2_arp_matcher_tb_top;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, entry_hit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cfg, arpc, spa_v, spm_v, tpa_v, tpm_v, d;
  logic [47:0] source_hw_addr, dest_hw_addr, frm_source_hw_addr, frm_dest_hw_addr;
  logic [47:0] arp_sha, arp_tha;
  logic [15:0] frm_len_type, arp_op, arp_hw_type, arp_proto_type;
  logic [7:0] arp_hw_len, arp_proto_len;
  logic [31:0] arp_spa, arp_tpa;
  logic [11:0] frm_vid;
  logic [2:0] frm_prio;
  logic frm_valid, exp_hit, er;
  logic [319:0] cfg_v;
  int fail_count, tests_run, hits, base;
  acl_entry_l2_arp_matcher dut (.clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .frm_valid, .frm_len_type,
    .frm_source_hw_addr, .frm_dest_hw_addr, .frm_vid, .frm_prio, .arp_op,
    .arp_hw_type, .arp_proto_type, .arp_hw_len, .arp_proto_len, .arp_sha,
    .arp_spa, .arp_tha, .arp_tpa, .entry_hit);
  acl_frame_src src (.clk, .frm_valid, .frm_len_type, .frm_source_hw_addr,
    .frm_dest_hw_addr, .frm_vid, .frm_prio, .arp_op, .arp_hw_type,
    .arp_proto_type, .arp_hw_len, .arp_proto_len, .arp_sha, .arp_spa,
    .arp_tha, .arp_tpa);
  always #2.5 clk = ~clk;
  task automatic check(input string nm, input logic [47:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb answer", {47'h0, pready}, 48'h1);
    // A slave that never answers ends the run as a failure
    if (pready !== 1'b1) end_sim();
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
    input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(nm, {16'h0, d}, {16'h0, e});
    check("pslverr", {47'h0, er}, {47'h0, ee});
  endtask
  // *****************************
  // Reference model
  // *****************************
  function automatic logic flag(input logic [1:0] f, input logic eq);
    flag = (f == acl_pkg::FLAG_SET) ? eq :
      (f == acl_pkg::FLAG_CLR) ? !eq : 1'b1;
  endfunction
  function automatic logic ipm(input logic [1:0] md, input logic [31:0] a,
    input logic [31:0] v, input logic [31:0] k);
    ipm = (md == acl_pkg::IPM_HOST) ? a == v :
      (md == acl_pkg::IPM_NET) ? (a & k) == (v & k) : 1'b1;
  endfunction
  function automatic logic model();
    logic [15:0] lt;
    logic m;
    lt = frm_len_type;
    case (cfg[2:0])
      3'h1: m = lt >= 16'h0600 &&
        !(lt inside {16'h0806, 16'h0800, 16'h86dd});
      3'h2: m = lt == 16'h0806;
      3'h3: m = lt == 16'h0800;
      3'h4: m = lt == 16'h86dd;
      default: m = 1'b1;
    endcase
    if (cfg[3] && cfg[2:0] inside {3'h1, 3'h2})
      m &= frm_source_hw_addr == source_hw_addr;
    case (cfg[6:4])
      3'h1: m &= frm_dest_hw_addr[40];
      3'h2: m &= &frm_dest_hw_addr;
      3'h3: m &= !frm_dest_hw_addr[40];
      3'h4: m &= frm_dest_hw_addr == dest_hw_addr;
      default: ;
    endcase
    if (cfg[7]) m &= frm_vid == cfg[23:12];
    if (cfg[8]) m &= frm_prio == cfg[11:9];
    if (cfg[2:0] == 3'h2) begin
      case (arpc[1:0])
        2'h1: m &= arp_op inside {16'h1, 16'h2};
        2'h2: m &= arp_op inside {16'h3, 16'h4};
        2'h3: m &= !(arp_op inside {[16'h1:16'h4]});
        default: ;
      endcase
      if (arpc[3:2] == 2'h1) m &= arp_op inside {16'h1, 16'h3};
      if (arpc[3:2] == 2'h2) m &= arp_op inside {16'h2, 16'h4};
      m &= ipm(arpc[5:4], arp_spa, spa_v, spm_v);
      m &= ipm(arpc[7:6], arp_tpa, tpa_v, tpm_v);
      m &= flag(arpc[9:8], arp_sha == frm_source_hw_addr);
      m &= flag(arpc[11:10], arp_tha == frm_source_hw_addr);
      m &= flag(arpc[13:12],
        arp_hw_len == 8'h06 && arp_proto_len == 8'h04);
      m &= flag(arpc[15:14], arp_hw_type == 16'h0001);
      m &= flag(arpc[17:16], arp_proto_type == 16'h0800);
    end
    model = m;
  endfunction
  always @(posedge clk) begin
    if (sys_rst) begin
      exp_hit <= 1'b0;
    end else begin
      check("entry_hit", {47'h0, entry_hit}, {47'h0, exp_hit});
      exp_hit <= frm_valid && model();
      if (frm_valid && model()) hits++;
    end
  end
  function automatic logic [1:0] pk(input int n);
    pk = ($urandom() % 2) ? 2'h0 : 2'($urandom() % n);
  endfunction
  // *****************************
  // Tests
  // *****************************
  initial begin
    #100_000;
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    void'($urandom(84280));
    {clk, psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("cfg", 8'h00, 32'h0, 1'b0);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rd_chk("cfg", 8'h00, 32'h00ff_ffff, 1'b0);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    rd_chk("arp", 8'h04, 32'h0003_ffff, 1'b0);
    $display("test registers done");
    rd_chk("unmapped", 8'h2c, 32'h0, 1'b1);
    apb(1'b1, 8'h01, 32'h1);
    check("unaligned", {47'h0, er}, 48'h1);
    $display("test refusal done");
    for (int c = 0; c < 100; c++) begin
      cfg = {8'h0, 12'($urandom()), 3'($urandom()), 2'($urandom()),
        3'($urandom() % 5), 1'($urandom()), 3'($urandom() % 5)};
      arpc = {14'h0, pk(4), pk(4), pk(4), pk(4), pk(4), pk(3), pk(3),
        pk(3), pk(4)};
      {source_hw_addr, dest_hw_addr} = {$urandom(), $urandom(), $urandom()};
      {spa_v, tpa_v} = {$urandom(), $urandom()};
      spm_v = 32'hffff_ffff << ($urandom() % 32);
      tpm_v = 32'hffff_ffff << ($urandom() % 32);
      cfg_v = {tpm_v, tpa_v, spm_v, spa_v, 16'h0, dest_hw_addr[47:32], dest_hw_addr[31:0],
        16'h0, source_hw_addr[47:32], source_hw_addr[31:0], arpc, cfg};
      // Config words sit at consecutive word offsets from zero
      for (int i = 0; i < 10; i++) apb(1'b1, 8'(4 * i), cfg_v[32 * i +: 32]);
      repeat (10) src.send(source_hw_addr, dest_hw_addr, spa_v, tpa_v, cfg[23:12], cfg[11:9]);
      @(posedge clk);
    end
    $display("test frames done, hits %0d", hits);
    rd_chk("hit count", 8'h28, 32'(hits), 1'b0);
    apb(1'b1, 8'h28, 32'h0);
    rd_chk("hit count", 8'h28, 32'h0, 1'b0);
    $display("test counter done");
    apb(1'b1, 8'h00, 32'h0000_00ff);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("cfg after reset", 8'h00, 32'h0, 1'b0);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
